// File: logic/msaf_pkg.sv
// Purpose: constants and carrier types for the modem status, scratch byte
//          and automatic flow control block of one serial channel.
// Assumes: one 200 MHz clock, byte-wide register port.
// Notes:   modem pin vectors are ordered {cd, ri, dsr, cts}.
`default_nettype none

package msaf_pkg;

  // Register offsets on the 4-bit address port
  localparam logic [3:0] ADDR_FEATURE = 4'h0;
  localparam logic [3:0] ADDR_MODEM_CTRL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_SCRATCH = 4'h3;
  localparam logic [3:0] ADDR_RESUME_1 = 4'h4;
  localparam logic [3:0] ADDR_RESUME_2 = 4'h5;
  localparam logic [3:0] ADDR_PAUSE_1 = 4'h6;
  localparam logic [3:0] ADDR_PAUSE_2 = 4'h7;

  // Field positions
  localparam int CTRL_DTR = 0;
  localparam int CTRL_RTS = 1;
  localparam int CTRL_AUX1 = 2;
  localparam int CTRL_AUX2 = 3;
  localparam int CTRL_LOOP = 4;
  localparam int FEAT_AUTO_CTS = 7;
  localparam int FEAT_AUTO_RTS = 6;
  localparam int MDM_CTS = 0;
  localparam int MDM_DSR = 1;
  localparam int MDM_RI = 2;
  localparam int MDM_CD = 3;

  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_FEATURE = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'hff;
  localparam logic [7:0] RST_CHAR = 8'h00;
  localparam logic [3:0] RST_PINS_N = 4'hf;
  localparam logic [1:0] SETTLE_DONE = 2'h3;

  // Receive level thresholds indexed by programmed trigger selection
  localparam logic [3:0][5:0] TRIG_LEVEL = {6'h1c, 6'h18, 6'h10, 6'h08};
  localparam logic [3:0][5:0] TRIG_UPPER = {6'h20, 6'h1c, 6'h18, 6'h10};
  localparam logic [3:0][5:0] TRIG_LOWER = {6'h18, 6'h10, 6'h08, 6'h01};

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } msaf_bus_type;

  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } msaf_modem_in_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } msaf_char_type;

  typedef enum logic {
    TX_IDLE,
    TX_SECOND
  } msaf_tx_state_type;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] feature;
    logic [7:0] scratch;
    logic [3:0][7:0] chars;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [3:0] delta;
    logic [1:0] settle;
    logic rts_flow;
    logic [7:0] rdata;
    logic rts_n;
    logic dtr_n;
    logic aux1_n;
    logic aux2_n;
    logic tx_enable;
    logic msi_irq;
    logic trig_irq;
    logic [1:0] rx_armed;
    msaf_tx_state_type tx_st;
    logic [7:0] tx_next;
    msaf_char_type tx_out;
    logic rx_resume;
    logic rx_pause;
  } msaf_state_type;

endpackage : msaf_pkg

`default_nettype wire

// File: logic/msaf_top.sv
// Purpose: modem status tracking, scratch byte, automatic and software
//          flow control for one serial channel.
// Assumes: all inputs synchronous except the modem pins.
// Notes:   read data appear one cycle after the read strobe.
`default_nettype none

module msaf_top (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire msaf_pkg::msaf_bus_type i_bus,
  output logic [7:0] o_rdata,
  input wire msaf_pkg::msaf_modem_in_type i_modem,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_aux1_n,
  output logic o_aux2_n,
  output logic o_tx_enable,
  output logic o_msi_irq,
  input wire logic [5:0] i_rx_level,
  input wire logic [1:0] i_trig_sel,
  output logic o_trig_irq,
  input wire msaf_pkg::msaf_char_type i_rx_char,
  output logic o_rx_resume,
  output logic o_rx_pause,
  input wire logic i_send_resume,
  input wire logic i_send_pause,
  output msaf_pkg::msaf_char_type o_tx_char
);

  //////////////////////////////////////////////////////////////////////////

  msaf_pkg::msaf_state_type s_q;
  msaf_pkg::msaf_state_type s_d;

  logic [3:0] eff_n;
  logic [3:0] edges;
  logic [7:0] status;
  logic loop_on;
  logic read_status;
  logic [1:0] tx_sel;
  logic [1:0] rx_sel;
  logic [5:0] level_up;
  logic [5:0] level_lo;
  logic [5:0] level_trig;
  logic [7:0] resume_1;
  logic [7:0] resume_2;
  logic [7:0] pause_1;
  logic [7:0] pause_2;

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d = s_q;
    loop_on = s_q.ctrl[msaf_pkg::CTRL_LOOP];
    resume_1 = s_q.chars[0];
    resume_2 = s_q.chars[1];
    pause_1 = s_q.chars[2];
    pause_2 = s_q.chars[3];
    tx_sel = s_q.feature[3:2];
    rx_sel = s_q.feature[1:0];
    level_up = msaf_pkg::TRIG_UPPER[i_trig_sel];
    level_lo = msaf_pkg::TRIG_LOWER[i_trig_sel];
    level_trig = msaf_pkg::TRIG_LEVEL[i_trig_sel];
    read_status = i_bus.rd && (i_bus.addr == msaf_pkg::ADDR_STATUS);

    // Pins pass two flops; only the second stage is looked at
    s_d.sync1 = i_modem;
    s_d.sync2 = s_q.sync1;

    // Loop-back feeds the control bits back as if they were pin levels
    if (loop_on) begin
      eff_n[msaf_pkg::MDM_CD] = ~s_q.ctrl[msaf_pkg::CTRL_AUX2];
      eff_n[msaf_pkg::MDM_RI] = ~s_q.ctrl[msaf_pkg::CTRL_AUX1];
      eff_n[msaf_pkg::MDM_DSR] = ~s_q.ctrl[msaf_pkg::CTRL_DTR];
      eff_n[msaf_pkg::MDM_CTS] = ~s_q.ctrl[msaf_pkg::CTRL_RTS];
    end else begin
      eff_n = s_q.sync2;
    end
    s_d.prev = eff_n;

    // Synchroniser contents are stale until it has filled after reset
    if (s_q.settle != msaf_pkg::SETTLE_DONE) begin
      s_d.settle = s_q.settle + 2'h1;
      edges = 4'h0;
    end else begin
      edges = eff_n ^ s_q.prev;
      // Ring flag only on the pin's 0 to 1 step
      edges[msaf_pkg::MDM_RI] =
        eff_n[msaf_pkg::MDM_RI] & ~s_q.prev[msaf_pkg::MDM_RI];
    end

    // A fresh edge wins over the clear of the same cycle
    s_d.delta = (read_status ? 4'h0 : s_q.delta) | edges;
    status = {~eff_n, s_q.delta};
    s_d.msi_irq = |s_d.delta;

    //////////////////////////////////////////////////////////////////////
    // Register port

    if (i_bus.wr) begin
      case (i_bus.addr)
        msaf_pkg::ADDR_FEATURE: s_d.feature = i_bus.wdata;
        msaf_pkg::ADDR_MODEM_CTRL: s_d.ctrl = i_bus.wdata;
        msaf_pkg::ADDR_SCRATCH: s_d.scratch = i_bus.wdata;
        msaf_pkg::ADDR_RESUME_1: s_d.chars[0] = i_bus.wdata;
        msaf_pkg::ADDR_RESUME_2: s_d.chars[1] = i_bus.wdata;
        msaf_pkg::ADDR_PAUSE_1: s_d.chars[2] = i_bus.wdata;
        msaf_pkg::ADDR_PAUSE_2: s_d.chars[3] = i_bus.wdata;
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end

    // Unmapped reads answer zero; data stand one cycle only
    s_d.rdata = 8'h00;
    if (i_bus.rd) begin
      case (i_bus.addr)
        msaf_pkg::ADDR_FEATURE: s_d.rdata = s_q.feature;
        msaf_pkg::ADDR_MODEM_CTRL: s_d.rdata = s_q.ctrl;
        msaf_pkg::ADDR_STATUS: s_d.rdata = status;
        msaf_pkg::ADDR_SCRATCH: s_d.rdata = s_q.scratch;
        msaf_pkg::ADDR_RESUME_1: s_d.rdata = resume_1;
        msaf_pkg::ADDR_RESUME_2: s_d.rdata = resume_2;
        msaf_pkg::ADDR_PAUSE_1: s_d.rdata = pause_1;
        msaf_pkg::ADDR_PAUSE_2: s_d.rdata = pause_2;
        default: s_d.rdata = 8'h00;
      endcase
    end

    //////////////////////////////////////////////////////////////////////
    // Hardware flow control

    // Pin high means the peer wants us to stop
    if (s_q.feature[msaf_pkg::FEAT_AUTO_CTS]) begin
      s_d.tx_enable = ~s_q.sync2[msaf_pkg::MDM_CTS];
    end else begin
      s_d.tx_enable = 1'b1;
    end

    // Hysteresis between the next upper and next lower level
    if (!s_q.feature[msaf_pkg::FEAT_AUTO_RTS]) begin
      s_d.rts_flow = 1'b0;
    end else if (i_rx_level >= level_up) begin
      s_d.rts_flow = 1'b1;
    end else if (i_rx_level < level_lo) begin
      s_d.rts_flow = 1'b0;
    end
    s_d.trig_irq = s_q.feature[msaf_pkg::FEAT_AUTO_RTS] &&
                   (i_rx_level >= level_trig);

    // Loop-back keeps the outside lines inactive
    if (loop_on) begin
      s_d.rts_n = 1'b1;
      s_d.dtr_n = 1'b1;
      s_d.aux1_n = 1'b1;
      s_d.aux2_n = 1'b1;
    end else begin
      if (s_q.feature[msaf_pkg::FEAT_AUTO_RTS]) begin
        s_d.rts_n = s_d.rts_flow;
      end else begin
        s_d.rts_n = ~s_q.ctrl[msaf_pkg::CTRL_RTS];
      end
      s_d.dtr_n = ~s_q.ctrl[msaf_pkg::CTRL_DTR];
      s_d.aux1_n = ~s_q.ctrl[msaf_pkg::CTRL_AUX1];
      s_d.aux2_n = ~s_q.ctrl[msaf_pkg::CTRL_AUX2];
    end

    //////////////////////////////////////////////////////////////////////
    // Software flow control characters, receive side

    s_d.rx_resume = 1'b0;
    s_d.rx_pause = 1'b0;
    if (i_rx_char.valid) begin
      case (rx_sel)
        2'h2: begin
          s_d.rx_resume = (i_rx_char.data == resume_1);
          s_d.rx_pause = (i_rx_char.data == pause_1);
          s_d.rx_armed = 2'h0;
        end
        2'h1: begin
          s_d.rx_resume = (i_rx_char.data == resume_2);
          s_d.rx_pause = (i_rx_char.data == pause_2);
          s_d.rx_armed = 2'h0;
        end
        2'h3: begin
          // Second character counts only right after the first
          s_d.rx_resume = s_q.rx_armed[0] &&
                          (i_rx_char.data == resume_2);
          s_d.rx_pause = s_q.rx_armed[1] &&
                         (i_rx_char.data == pause_2);
          s_d.rx_armed[0] = (i_rx_char.data == resume_1);
          s_d.rx_armed[1] = (i_rx_char.data == pause_1);
        end
        default: s_d.rx_armed = 2'h0;
      endcase
    end

    //////////////////////////////////////////////////////////////////////
    // Software flow control characters, transmit side

    s_d.tx_out.valid = 1'b0;
    s_d.tx_out.data = s_q.tx_out.data;
    case (s_q.tx_st)
      msaf_pkg::TX_IDLE: begin
        // Pause takes priority when both are asked together
        if ((i_send_pause || i_send_resume) && (tx_sel != 2'h0)) begin
          s_d.tx_out.valid = 1'b1;
          case (tx_sel)
            2'h2: s_d.tx_out.data = i_send_pause ? pause_1 : resume_1;
            2'h1: s_d.tx_out.data = i_send_pause ? pause_2 : resume_2;
            default: begin
              s_d.tx_out.data = i_send_pause ? pause_1 : resume_1;
              s_d.tx_next = i_send_pause ? pause_2 : resume_2;
              s_d.tx_st = msaf_pkg::TX_SECOND;
            end
          endcase
        end
      end
      msaf_pkg::TX_SECOND: begin
        s_d.tx_out.valid = 1'b1;
        s_d.tx_out.data = s_q.tx_next;
        s_d.tx_st = msaf_pkg::TX_IDLE;
      end
      default: s_d.tx_st = msaf_pkg::TX_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q.ctrl <= msaf_pkg::RST_CTRL;
      s_q.feature <= msaf_pkg::RST_FEATURE;
      s_q.scratch <= msaf_pkg::RST_SCRATCH;
      s_q.chars <= {4{msaf_pkg::RST_CHAR}};
      s_q.sync1 <= msaf_pkg::RST_PINS_N;
      s_q.sync2 <= msaf_pkg::RST_PINS_N;
      s_q.prev <= msaf_pkg::RST_PINS_N;
      s_q.delta <= 4'h0;
      s_q.settle <= 2'h0;
      s_q.rts_flow <= 1'b0;
      s_q.rdata <= 8'h00;
      s_q.rts_n <= 1'b1;
      s_q.dtr_n <= 1'b1;
      s_q.aux1_n <= 1'b1;
      s_q.aux2_n <= 1'b1;
      s_q.tx_enable <= 1'b1;
      s_q.msi_irq <= 1'b0;
      s_q.trig_irq <= 1'b0;
      s_q.rx_armed <= 2'h0;
      s_q.tx_st <= msaf_pkg::TX_IDLE;
      s_q.tx_next <= 8'h00;
      s_q.tx_out <= '0;
      s_q.rx_resume <= 1'b0;
      s_q.rx_pause <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  assign o_rdata = s_q.rdata;
  assign o_rts_n = s_q.rts_n;
  assign o_dtr_n = s_q.dtr_n;
  assign o_aux1_n = s_q.aux1_n;
  assign o_aux2_n = s_q.aux2_n;
  assign o_tx_enable = s_q.tx_enable;
  assign o_msi_irq = s_q.msi_irq;
  assign o_trig_irq = s_q.trig_irq;
  assign o_rx_resume = s_q.rx_resume;
  assign o_rx_pause = s_q.rx_pause;
  assign o_tx_char = s_q.tx_out;

endmodule : msaf_top

`default_nettype wire

// File: bench/msaf_modem_model.sv
// Purpose: modem side of the control lines, moving pins on request
// Assumes: pins are active low and idle high
// Notes:   pins move on the falling edge, off the sampling edge
`default_nettype none

module msaf_modem_model (
  input wire logic i_clk,
  input wire msaf_pkg::msaf_modem_in_type i_want,
  input wire logic [3:0] i_lag,
  output msaf_pkg::msaf_modem_in_type o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;

  initial o_pins = msaf_pkg::RST_PINS_N;

  // A slow modem answers some cycles after being asked
  always @(negedge i_clk) begin
    if (i_want == o_pins) begin
      cnt = 0;
    end else if (cnt >= int'(i_lag)) begin
      o_pins = i_want;
      cnt = 0;
    end else begin
      cnt++;
    end
  end
endmodule : msaf_modem_model

`default_nettype wire

// File: bench/msaf_chk.sv
// Purpose: timing properties of status, interrupt and flow control
// Assumes: register shadows follow bus writes seen at the ports
// Notes:   quiet_q counts cycles with calm pins and unchanged control
`default_nettype none

module msaf_chk (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire msaf_pkg::msaf_bus_type i_bus,
  input wire logic [7:0] o_rdata,
  input wire msaf_pkg::msaf_modem_in_type i_modem,
  input wire logic o_rts_n,
  input wire logic o_dtr_n,
  input wire logic o_tx_enable,
  input wire logic o_msi_irq,
  input wire logic [5:0] i_rx_level,
  input wire logic [1:0] i_trig_sel,
  input wire logic o_trig_irq
);
  logic [7:0] feat_q, ctrl_q;
  logic [3:0] quiet_q;
  logic clr_q, rds, wm, cts, up, lo, tr;

  assign rds = i_bus.rd && i_bus.addr == msaf_pkg::ADDR_STATUS;
  assign wm = i_bus.wr && i_bus.addr == msaf_pkg::ADDR_MODEM_CTRL;
  assign cts = i_modem.cts_n;
  assign up = i_rx_level >= msaf_pkg::TRIG_UPPER[i_trig_sel];
  assign lo = i_rx_level < msaf_pkg::TRIG_LOWER[i_trig_sel];
  assign tr = feat_q[6] && i_rx_level >= msaf_pkg::TRIG_LEVEL[i_trig_sel];

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      feat_q <= 8'h00;
      ctrl_q <= 8'h00;
      quiet_q <= 4'h0;
      clr_q <= 1'b0;
    end else begin
      if (i_bus.wr && i_bus.addr == msaf_pkg::ADDR_FEATURE)
        feat_q <= i_bus.wdata;
      if (wm)
        ctrl_q <= i_bus.wdata;
      // Loop-back control moves the status too, so it breaks the calm
      if ($changed(i_modem) || wm) begin
        quiet_q <= 4'h0;
        clr_q <= 1'b0;
      end else begin
        if (quiet_q != 4'hf)
          quiet_q <= quiet_q + 4'h1;
        if (rds && quiet_q >= 4'h4)
          clr_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_change_irq: assert property (!ctrl_q[4] && ($changed(i_modem.cd_n) ||
    $changed(i_modem.dsr_n) || $changed(cts) || $rose(i_modem.ri_n))
    ##1 !rds [*3] |-> ##[0:1] o_msi_irq)
    else $error("change flag gave no interrupt");
  a_read_clear: assert property (rds && clr_q |=> o_rdata[3:0] == 4'h0)
    else $error("change flags survived a read");
  a_irq_clear: assert property (clr_q && $past(clr_q) |-> !o_msi_irq)
    else $error("interrupt without change flag");
  a_status_bits: assert property (rds && quiet_q >= 4'h4 |=> o_rdata[7:4] ==
    (ctrl_q[4] ? {ctrl_q[3:2], ctrl_q[0], ctrl_q[1]} : ~4'($past(i_modem))))
    else $error("status state bits wrong");
  a_cts_stop: assert property ((feat_q[7] && cts) [*4] |-> !o_tx_enable)
    else $error("transmitter not stopped");
  a_cts_resume: assert property ((feat_q[7] && !cts) [*4] |-> o_tx_enable)
    else $error("transmitter not resumed");
  a_cts_ignore: assert property (!feat_q[7] [*2] |-> o_tx_enable)
    else $error("transmitter gated while auto off");
  a_rts_manual: assert property ((!feat_q[6] && !ctrl_q[4] && $stable(ctrl_q))
    [*3] |-> o_rts_n == !ctrl_q[1] && o_dtr_n == !ctrl_q[0])
    else $error("modem outputs differ from control");
  a_rts_high: assert property ((feat_q[6] && up) [*3] |-> o_rts_n)
    else $error("request-to-send not raised");
  a_rts_low: assert property ((feat_q[6] && lo && ctrl_q[1] && !ctrl_q[4])
    [*3] |-> !o_rts_n)
    else $error("request-to-send not returned");
  a_trig_irq: assert property ($past(tr) == tr |-> o_trig_irq == tr)
    else $error("trigger interrupt wrong");
endmodule : msaf_chk

bind msaf_top msaf_chk msaf_chk_inst (.i_clk, .i_reset, .i_bus, .o_rdata,
  .i_modem, .o_rts_n, .o_dtr_n, .o_tx_enable, .o_msi_irq, .i_rx_level,
  .i_trig_sel, .o_trig_irq);

`default_nettype wire

// File: bench/msaf_tb.sv
// Purpose: self-checking bench for the status and flow control block
// Assumes: 200 MHz clock, modem model on the pins
// Notes:   reads queue their expected byte and mask for the monitor
`default_nettype none

module msaf_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  msaf_pkg::msaf_bus_type i_bus = '0;
  msaf_pkg::msaf_modem_in_type i_modem, want = 4'hf;
  msaf_pkg::msaf_char_type o_tx_char;
  logic [7:0] o_rdata, v;
  logic o_rts_n, o_dtr_n, o_aux1_n, o_aux2_n, o_tx_enable;
  logic o_msi_irq, o_trig_irq, rd_d;
  logic o_rx_resume, o_rx_pause;
  msaf_pkg::msaf_char_type i_rx_char = '0;
  logic [5:0] i_rx_level = 6'h00;
  logic [5:0] lv [5];
  logic [1:0] i_trig_sel = 2'h0;
  logic [3:0] lag = 4'h0, nw, fl;
  logic i_send_pause = 1'b0;
  logic [15:0] exp_q[$], ent;
  int err_count = 0;
  int checks_done = 0;

  msaf_top msaf_top_inst (.i_clk, .i_reset, .i_bus, .o_rdata, .i_modem,
    .o_rts_n, .o_dtr_n, .o_aux1_n, .o_aux2_n, .o_tx_enable, .o_msi_irq,
    .i_rx_level, .i_trig_sel, .o_trig_irq, .i_rx_char,
    .o_rx_resume, .o_rx_pause, .i_send_resume(1'b0), .i_send_pause,
    .o_tx_char);
  msaf_modem_model modem_inst (.i_clk, .i_want(want), .i_lag(lag),
    .o_pins(i_modem));

  always #2.5 i_clk = ~i_clk;

  //////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_byte(input logic [7:0] e, g, input string n);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic e, g, input string n);
    chk_byte({7'h0, e}, {7'h0, g}, n);
  endtask : chk_bit

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  // Gap cycle after each access keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_bus <= '{1'b1, 1'b0, a, d};
    tick(1);
    i_bus <= '0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, m);
    exp_q.push_back({e & m, m});
    i_bus <= '{1'b0, 1'b1, a, 8'h00};
    tick(1);
    i_bus <= '0;
    tick(1);
  endtask : rd

  always @(posedge i_clk) begin
    if (rd_d === 1'b1) begin
      ent = exp_q.pop_front();
      chk_byte(ent[15:8], o_rdata & ent[7:0], "read data");
    end
    rd_d = i_bus.rd;
  end

  initial begin
    tick(20000);
    err_count++;
    print_verdict();
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h4ca1));
    tick(8);
    i_reset <= 1'b0;
    tick(1);
    chk_bit(1'b1, o_rts_n, "rts out");
    chk_bit(1'b0, o_msi_irq, "modem irq");
    rd(msaf_pkg::ADDR_STATUS, 8'h00, 8'hff);
    rd(msaf_pkg::ADDR_FEATURE, 8'h00, 8'hff);
    rd(msaf_pkg::ADDR_SCRATCH, msaf_pkg::RST_SCRATCH, 8'hff);
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wr(msaf_pkg::ADDR_SCRATCH, v);
      wr(4'h8 + 4'(k), ~v);
      rd(msaf_pkg::ADDR_SCRATCH, v, 8'hff);
      rd(4'h8 + 4'(k), 8'h00, 8'hff);
    end
    // Each pin falls then rises; a falling ring pin leaves no flag
    for (int k = 0; k < 8; k++) begin
      nw = want ^ (4'h1 << (k % 4));
      fl = (k == 2) ? 4'h0 : 4'h1 << (k % 4);
      lag <= 4'($urandom_range(3));
      want <= nw;
      tick(10);
      chk_bit(|fl, o_msi_irq, "modem irq");
      rd(msaf_pkg::ADDR_STATUS, {~nw, fl}, 8'hff);
      rd(msaf_pkg::ADDR_STATUS, {~nw, 4'h0}, 8'hff);
      tick(2);
      chk_bit(1'b0, o_msi_irq, "modem irq");
    end
    want <= 4'h0;
    for (int k = 0; k < 16; k++) begin
      wr(msaf_pkg::ADDR_MODEM_CTRL, 8'h10 | 8'(k));
      tick(4);
      rd(msaf_pkg::ADDR_STATUS, {k[3:2], k[0], k[1], 4'h0}, 8'hf0);
      chk_bit(1'b1, o_rts_n & o_dtr_n, "loop outputs");
    end
    for (int k = 0; k < 4; k++) begin
      wr(msaf_pkg::ADDR_MODEM_CTRL, 8'h1 << k);
      tick(3);
      chk_byte({4'h0, ~(4'h1 << k)},
        {4'h0, o_aux2_n, o_aux1_n, o_rts_n, o_dtr_n}, "modem outputs");
    end
    wr(msaf_pkg::ADDR_MODEM_CTRL, 8'h00);
    for (int k = 0; k < 5; k++) begin
      if (k == 2)
        wr(msaf_pkg::ADDR_FEATURE, 8'h80);
      want <= {3'h7, k[0]};
      tick(8);
      chk_bit(k < 2 || !k[0], o_tx_enable, "tx enable");
    end
    wr(msaf_pkg::ADDR_FEATURE, 8'h40);
    wr(msaf_pkg::ADDR_MODEM_CTRL, 8'h02);
    for (int s = 0; s < 4; s++) begin
      lv = '{6'h00, msaf_pkg::TRIG_LEVEL[s], msaf_pkg::TRIG_UPPER[s],
        msaf_pkg::TRIG_LOWER[s], msaf_pkg::TRIG_LOWER[s] - 6'h1};
      i_trig_sel <= 2'(s);
      for (int j = 0; j < 5; j++) begin
        i_rx_level <= lv[j];
        tick(3);
        chk_bit(j == 1 || j == 2, o_trig_irq, "trigger irq");
        chk_bit(j == 2 || j == 3, o_rts_n, "rts out");
      end
    end
    // Two pause characters leave back to back
    wr(msaf_pkg::ADDR_FEATURE, 8'h0f);
    wr(msaf_pkg::ADDR_PAUSE_1, v);
    wr(msaf_pkg::ADDR_PAUSE_2, ~v);
    i_send_pause <= 1'b1;
    tick(1);
    i_send_pause <= 1'b0;
    tick(1);
    chk_byte(v, o_tx_char.data, "first pause char");
    tick(1);
    chk_byte(~v, o_tx_char.data, "second pause char");
    chk_bit(1'b1, o_tx_char.valid, "char valid");
    tick(1);
    chk_bit(1'b0, o_tx_char.valid, "char valid");
    chk_bit(1'b0, o_rts_n, "rts out");
    // Two pause characters in a row make one receive match
    i_rx_char <= '{1'b1, v};
    tick(1);
    i_rx_char <= '{1'b1, ~v};
    tick(1);
    i_rx_char <= '0;
    tick(1);
    chk_bit(1'b1, o_rx_pause, "rx pause match");
    chk_bit(1'b0, o_rx_resume, "rx resume match");
    tick(1);
    chk_bit(1'b0, o_rx_pause, "rx pause match");
    tick(3);
    print_verdict();
  end
endmodule : msaf_tb

`default_nettype wire
